//--- wcc_defs.svh
`ifndef WCC_DEFS_SVH
`define WCC_DEFS_SVH

`define WCC_LANES 18
`define WCC_BEATS 10
`define WCC_DATA_BEATS 8
`define WCC_CHOP_BEATS 4
`define WCC_NIBBLE 4
`define WCC_LANE_BITS 8
`define WCC_GRP_LANES 9
`define WCC_GRP_BITS 72
`define WCC_DATA_BITS 144
`define WCC_CRC_BITS 8
`define WCC_CRC_ALL 16
`define WCC_MASK_LANE 8
`define WCC_X4_LANES 4
`define WCC_CRC_BEAT 8
`define WCC_LAST_BEAT 9
`define WCC_CRC_POLY 8'h07
`define WCC_CRC_INIT 8'h00
`define WCC_FIFO_DEPTH 16

`endif

//--- wcc_pkg.sv
`include "wcc_defs.svh"

package wcc_pkg;

  typedef enum logic [1:0] {
    ORG_X4 = 2'h0,
    ORG_X8 = 2'h1,
    ORG_X16 = 2'h2
  } wccOrg_t;

  typedef enum logic [2:0] {
    LS_IDLE = 3'h1,
    LS_DATA = 3'h2,
    LS_CRC = 3'h4
  } wccLinkSt_t;

  // Raw burst as it arrived: bit lane*8+beat for beats 0..7.
  typedef struct packed {
    logic a2;
    logic chop;
    logic [`WCC_DATA_BITS-1:0] beats;
    logic [`WCC_LANES-1:0] beatCrc;
    logic [`WCC_LANES-1:0] beatLast;
  } wccFrame_t;

  typedef struct packed {
    logic a2;
    logic chop;
    logic [`WCC_DATA_BITS-1:0] data;
    logic [`WCC_CRC_ALL-1:0] crcCalc;
    logic [`WCC_CRC_ALL-1:0] crcRecv;
    logic [1:0] crcErr;
    logic fillErr;
  } wccResult_t;

endpackage

//--- wcc_fifo.sv
`timescale 1ns/100ps

module wcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    wrPtr_d = push ? bump(wrPtr_q) : wrPtr_q;
    rdPtr_d = pop ? bump(rdPtr_q) : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + (AW+1)'(1);
    end else if (pop && !push) begin
      count_d = count_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage carries no reset; only the pointers and the count decide what is valid.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

endmodule

//--- wcc_top.sv
`timescale 1ns/100ps
`include "wcc_defs.svh"

module wcc_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire wcc_pkg::wccOrg_t cfgOrg,
  input wire logic cfgMaskInvEn,
  input wire logic linkClk,
  input wire logic burstStart,
  input wire logic cmdA2,
  input wire logic burstChopFour,
  input wire logic [15:0] dqIn,
  input wire logic lowerMaskInvertN,
  input wire logic upperMaskInvertN,
  output logic linkBusy,
  input wire logic resReady,
  output logic resValid,
  output wcc_pkg::wccResult_t resData,
  output logic overrunPulse
);
  import wcc_pkg::*;

  // Reset release, one copy per clock domain.
  logic sysRst1_q, sysRstN_q, lnkRst1_q, lnkRstN_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sysRst1_q <= 1'b0;
      sysRstN_q <= 1'b0;
    end else begin
      sysRst1_q <= 1'b1;
      sysRstN_q <= sysRst1_q;
    end
  end

  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      lnkRst1_q <= 1'b0;
      lnkRstN_q <= 1'b0;
    end else begin
      lnkRst1_q <= 1'b1;
      lnkRstN_q <= lnkRst1_q;
    end
  end

  // ---------------- Link domain: gather one write burst. ----------------
  wccLinkSt_t lst_q, lst_d;
  logic [3:0] beat_q, beat_d;
  wccFrame_t acc_q, acc_d, hold_q, hold_d;
  logic req_q, req_d, ovf_q, ovf_d, busy_q, busy_d;
  logic ackL1_q, ackL2_q;
  logic ack_q, ack_d;
  logic [`WCC_LANES-1:0] pins;

  assign pins = {upperMaskInvertN, dqIn[15:8], lowerMaskInvertN, dqIn[7:0]};

  function automatic wccFrame_t putBeat(input wccFrame_t f,
                                        input logic [3:0] b,
                                        input logic [`WCC_LANES-1:0] v);
    wccFrame_t r;
    r = f;
    for (int l = 0; l < `WCC_LANES; l++) begin
      if (b < 4'(`WCC_DATA_BEATS)) begin
        r.beats[l*`WCC_LANE_BITS + int'(b)] = v[l];
      end
    end
    if (b == 4'(`WCC_CRC_BEAT)) begin
      r.beatCrc = v;
    end else if (b == 4'(`WCC_LAST_BEAT)) begin
      r.beatLast = v;
    end
    return r;
  endfunction

  always_comb begin
    lst_d = lst_q;
    beat_d = beat_q;
    acc_d = acc_q;
    hold_d = hold_q;
    req_d = req_q;
    ovf_d = ovf_q;
    busy_d = (req_q != ackL2_q);
    case (lst_q)
      LS_IDLE: begin
        if (burstStart) begin
          acc_d = putBeat(acc_q, 4'h0, pins);
          acc_d.a2 = cmdA2;
          acc_d.chop = burstChopFour;
          beat_d = 4'h1;
          lst_d = LS_DATA;
        end
      end
      LS_DATA: begin
        acc_d = putBeat(acc_q, beat_q, pins);
        beat_d = beat_q + 4'h1;
        if (beat_q == 4'(`WCC_DATA_BEATS - 1)) begin
          lst_d = LS_CRC;
        end
      end
      LS_CRC: begin
        acc_d = putBeat(acc_q, beat_q, pins);
        beat_d = beat_q + 4'h1;
        if (beat_q == 4'(`WCC_LAST_BEAT)) begin
          lst_d = LS_IDLE;
          beat_d = 4'h0;
          // The clock may stop after this beat, so the hand-off is
          // launched here and judged again only at the next burst end.
          if (req_q == ackL2_q) begin
            hold_d = putBeat(acc_q, beat_q, pins);
            req_d = ~req_q;
            busy_d = 1'b1;
          end else begin
            ovf_d = ~ovf_q;
          end
        end
      end
      default: begin
        lst_d = LS_IDLE;
        beat_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge linkClk or negedge lnkRstN_q) begin
    if (!lnkRstN_q) begin
      lst_q <= LS_IDLE;
      beat_q <= 4'h0;
      acc_q <= '0;
      hold_q <= '0;
      req_q <= 1'b0;
      ovf_q <= 1'b0;
      busy_q <= 1'b0;
      ackL1_q <= 1'b0;
      ackL2_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      beat_q <= beat_d;
      acc_q <= acc_d;
      hold_q <= hold_d;
      req_q <= req_d;
      ovf_q <= ovf_d;
      busy_q <= busy_d;
      ackL1_q <= ack_q;
      ackL2_q <= ackL1_q;
    end
  end

  assign linkBusy = busy_q;

  // ---------------- System domain: take bursts into the FIFO. ----------
  logic reqS1_q, reqS2_q, ovfS1_q, ovfS2_q, ovfSeen_q;
  logic ovrPulse_q, ovrPulse_d;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  wccFrame_t fifoOut;

  // The held frame is stable while the request is outstanding, so the
  // wide word needs no synchroniser of its own.
  assign fifoInValid = (reqS2_q != ack_q);

  always_comb begin
    ack_d = ack_q;
    if (fifoInValid && fifoInReady) begin
      ack_d = ~ack_q;
    end
    ovrPulse_d = (ovfS2_q != ovfSeen_q);
  end

  always_ff @(posedge sys_clk or negedge sysRstN_q) begin
    if (!sysRstN_q) begin
      reqS1_q <= 1'b0;
      reqS2_q <= 1'b0;
      ovfS1_q <= 1'b0;
      ovfS2_q <= 1'b0;
      ovfSeen_q <= 1'b0;
      ack_q <= 1'b0;
      ovrPulse_q <= 1'b0;
    end else begin
      reqS1_q <= req_q;
      reqS2_q <= reqS1_q;
      ovfS1_q <= ovf_q;
      ovfS2_q <= ovfS1_q;
      ovfSeen_q <= ovfS2_q;
      ack_q <= ack_d;
      ovrPulse_q <= ovrPulse_d;
    end
  end

  assign overrunPulse = ovrPulse_q;

  wcc_fifo #(
    .WIDTH($bits(wccFrame_t)),
    .DEPTH(`WCC_FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rstN(sysRstN_q),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(hold_q),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  // ---------------- System domain: map, compute and compare. ----------

  // Places the wire beats at their storage positions; a chopped burst
  // with A2 set lands in the upper nibble of each lane.
  function automatic logic [`WCC_DATA_BITS-1:0] placeData(
      input wccFrame_t f);
    logic [`WCC_DATA_BITS-1:0] d;
    int off;
    d = f.beats;
    off = f.a2 ? `WCC_NIBBLE : 0;
    if (f.chop) begin
      d = '1;
      for (int l = 0; l < `WCC_LANES; l++) begin
        for (int k = 0; k < `WCC_CHOP_BEATS; k++) begin
          d[l*`WCC_LANE_BITS + off + k] = f.beats[l*`WCC_LANE_BITS + k];
        end
      end
    end
    return d;
  endfunction

  // Builds the 72 tree inputs of one byte group.
  function automatic logic [`WCC_GRP_BITS-1:0] treeIn(
      input logic [`WCC_GRP_BITS-1:0] d,
      input logic a2,
      input logic chop,
      input logic maskEn,
      input logic x4);
    logic [`WCC_GRP_BITS-1:0] t;
    int p;
    t = d;
    for (int l = 0; l < `WCC_GRP_LANES; l++) begin
      for (int k = 0; k < `WCC_LANE_BITS; k++) begin
        p = l*`WCC_LANE_BITS + k;
        if (chop) begin
          if (k < `WCC_NIBBLE) begin
            t[p] = a2 ? d[p + `WCC_NIBBLE] : d[p];
          end else begin
            t[p] = 1'b1;
          end
        end
        if (l == `WCC_MASK_LANE && !maskEn) begin
          t[p] = 1'b1;
        end
        if (x4 && l >= `WCC_X4_LANES) begin
          t[p] = 1'b1;
        end
      end
    end
    return t;
  endfunction

  // Serial form of the parallel XOR tree, highest input first.
  function automatic logic [`WCC_CRC_BITS-1:0] crc72(
      input logic [`WCC_GRP_BITS-1:0] t);
    logic [`WCC_CRC_BITS-1:0] c;
    logic fb;
    c = `WCC_CRC_INIT;
    for (int i = `WCC_GRP_BITS - 1; i >= 0; i--) begin
      fb = c[`WCC_CRC_BITS-1] ^ t[i];
      c = {c[`WCC_CRC_BITS-2:0], 1'b0} ^ (fb ? `WCC_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  logic resValid_q, resValid_d;
  wccResult_t res_q, res_d;
  logic [`WCC_DATA_BITS-1:0] dWord;
  logic [`WCC_GRP_BITS-1:0] tLo, tHi;
  logic isX4, isX16, fillBad;

  assign fifoOutReady = !resValid_q || resReady;

  always_comb begin
    isX4 = (cfgOrg == ORG_X4);
    isX16 = (cfgOrg == ORG_X16);
    dWord = placeData(fifoOut);
    tLo = treeIn(dWord[`WCC_GRP_BITS-1:0], fifoOut.a2, fifoOut.chop,
                 cfgMaskInvEn && !isX4, isX4);
    tHi = treeIn(dWord[`WCC_DATA_BITS-1:`WCC_GRP_BITS], fifoOut.a2,
                 fifoOut.chop, cfgMaskInvEn, 1'b0);
    fillBad = 1'b0;
    // In a chop, beats 4..7 must idle high; always CRC-beat lanes 8 and 17, and outside x4 the whole last beat, too.
    for (int l = 0; l < `WCC_LANES; l++) begin
      for (int k = `WCC_CHOP_BEATS; k < `WCC_DATA_BEATS; k++) begin
        if (fifoOut.chop && !fifoOut.beats[l*`WCC_LANE_BITS + k]) begin
          fillBad = 1'b1;
        end
      end
    end
    if (!isX4 && fifoOut.beatLast != '1) begin
      fillBad = 1'b1;
    end
    if (!fifoOut.beatCrc[`WCC_MASK_LANE] ||
        !fifoOut.beatCrc[`WCC_LANES-1]) begin
      fillBad = 1'b1;
    end

    res_d = res_q;
    resValid_d = resValid_q && !resReady;
    if (fifoOutValid && fifoOutReady) begin
      resValid_d = 1'b1;
      res_d.a2 = fifoOut.a2;
      res_d.chop = fifoOut.chop;
      res_d.data = dWord;
      // Lanes kept off the trees by x4 or a disabled mask lane read back as ones, as on the tree.
      if (isX4) begin
        res_d.data[`WCC_DATA_BITS-1:`WCC_X4_LANES*`WCC_LANE_BITS] = '1;
      end
      if (isX4 || !cfgMaskInvEn) begin
        res_d.data[`WCC_GRP_BITS-1:`WCC_GRP_BITS-`WCC_LANE_BITS] = '1;
        res_d.data[`WCC_DATA_BITS-1:`WCC_DATA_BITS-`WCC_LANE_BITS] =
          '1;
      end
      res_d.crcCalc = '0;
      res_d.crcCalc[`WCC_CRC_BITS-1:0] = crc72(tLo);
      if (isX16) begin
        res_d.crcCalc[`WCC_CRC_ALL-1:`WCC_CRC_BITS] = crc72(tHi);
      end
      res_d.crcRecv = '0;
      if (isX4) begin
        res_d.crcRecv[`WCC_CRC_BITS-1:0] =
          {fifoOut.beatLast[`WCC_X4_LANES-1:0],
           fifoOut.beatCrc[`WCC_X4_LANES-1:0]};
      end else begin
        res_d.crcRecv[`WCC_CRC_BITS-1:0] =
          fifoOut.beatCrc[`WCC_CRC_BITS-1:0];
      end
      if (isX16) begin
        res_d.crcRecv[`WCC_CRC_ALL-1:`WCC_CRC_BITS] =
          fifoOut.beatCrc[`WCC_LANES-2:`WCC_MASK_LANE+1];
      end
      res_d.crcErr[0] = (res_d.crcCalc[`WCC_CRC_BITS-1:0] !=
                         res_d.crcRecv[`WCC_CRC_BITS-1:0]);
      res_d.crcErr[1] = isX16 &&
        (res_d.crcCalc[`WCC_CRC_ALL-1:`WCC_CRC_BITS] !=
         res_d.crcRecv[`WCC_CRC_ALL-1:`WCC_CRC_BITS]);
      res_d.fillErr = fillBad;
    end
  end

  always_ff @(posedge sys_clk or negedge sysRstN_q) begin
    if (!sysRstN_q) begin
      resValid_q <= 1'b0;
      res_q <= '0;
    end else begin
      resValid_q <= resValid_d;
      res_q <= res_d;
    end
  end

  assign resValid = resValid_q;
  assign resData = res_q;

endmodule

//--- wcc_chk_properties.sv
`timescale 1ns/100ps
module wcc_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire wcc_pkg::wccOrg_t cfgOrg,
  input wire logic cfgMaskInvEn,
  input wire logic resReady,
  input wire logic resValid,
  input wire wcc_pkg::wccResult_t resData,
  input wire logic overrunPulse
);
  import wcc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_result_holds: assert property (
    resValid && !resReady |=> resValid && $stable(resData))
    else $error("result changed before it was taken");
  a_err_lower: assert property (resValid |->
    resData.crcErr[0] == (resData.crcCalc[7:0] != resData.crcRecv[7:0]))
    else $error("lower tree error flag wrong");
  a_err_upper: assert property (resValid && cfgOrg == ORG_X16 |->
    resData.crcErr[1] == (resData.crcCalc[15:8] != resData.crcRecv[15:8]))
    else $error("upper tree error flag wrong");
  a_err_single: assert property (
    resValid && cfgOrg != ORG_X16 |-> !resData.crcErr[1])
    else $error("upper tree flag without second tree");
  a_chop_low: assert property (resValid && resData.chop && !resData.a2 |->
    resData.data[7:4] == 4'hf && resData.data[79:76] == 4'hf)
    else $error("uncarried upper nibble not ones");
  a_chop_high: assert property (resValid && resData.chop && resData.a2 |->
    resData.data[3:0] == 4'hf && resData.data[75:72] == 4'hf)
    else $error("uncarried lower nibble not ones");
  a_mask_off: assert property (resValid && !cfgMaskInvEn |->
    resData.data[71:64] == 8'hff && resData.data[143:136] == 8'hff)
    else $error("disabled mask lane not ones");
  a_x4_unused: assert property (
    resValid && cfgOrg == ORG_X4 |-> &resData.data[143:32])
    else $error("unused lanes not ones");
  a_drop_once: assert property (overrunPulse |=> !overrunPulse)
    else $error("drop pulse longer than one cycle");
endmodule

bind wcc_top wcc_chk i_chk (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .cfgOrg(cfgOrg),
  .cfgMaskInvEn(cfgMaskInvEn),
  .resReady(resReady),
  .resValid(resValid),
  .resData(resData),
  .overrunPulse(overrunPulse)
);

//--- wcc_ctrl_model.sv
`timescale 1ns/100ps
module wcc_ctrl_model (
  output logic linkClk,
  output logic burstStart,
  output logic cmdA2,
  output logic burstChopFour,
  output logic [15:0] dqIn,
  output logic lowerMaskInvertN,
  output logic upperMaskInvertN
);
  import wcc_pkg::*;

  initial begin
    linkClk = 1'b0;
    burstStart = 1'b0;
    cmdA2 = 1'b0;
    burstChopFour = 1'b0;
    dqIn = 16'h0000;
    lowerMaskInvertN = 1'b1;
    upperMaskInvertN = 1'b1;
  end

  task automatic tick();
    #62.5 linkClk = 1'b1;
    #62.5 linkClk = 1'b0;
  endtask

  // The link clock only runs inside a frame and its lead ticks, so idle lanes show the inverse
  // of the last beat rather than a value the device could latch by luck.
  task automatic send(input wccFrame_t f, input int lead);
    logic [17:0] v;
    #1.3;
    repeat (lead) tick();
    for (int b = 0; b < 10; b++) begin
      for (int l = 0; l < 18; l++) begin
        if (b < 8) v[l] = f.beats[l*8+b];
        else if (b == 8) v[l] = f.beatCrc[l];
        else v[l] = f.beatLast[l];
      end
      burstStart = (b == 0);
      cmdA2 = f.a2;
      burstChopFour = f.chop;
      dqIn = {v[16:9], v[7:0]};
      lowerMaskInvertN = v[8];
      upperMaskInvertN = v[17];
      tick();
    end
    burstStart = 1'b0;
    cmdA2 = ~cmdA2;
    dqIn = ~dqIn;
    lowerMaskInvertN = ~lowerMaskInvertN;
    upperMaskInvertN = ~upperMaskInvertN;
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import wcc_pkg::*;
  logic sys_clk, arst_n, cfgMaskInvEn, resReady, resValid, overrunPulse;
  logic linkClk, burstStart, cmdA2, burstChopFour, linkBusy;
  logic lowerMaskInvertN, upperMaskInvertN;
  logic [15:0] dqIn;
  wccOrg_t cfgOrg;
  wccResult_t resData;
  wccResult_t expQ[$];
  wccResult_t maskQ[$];
  int errors, compares, drops, seq;

  wcc_top i_dut(.sys_clk(sys_clk), .arst_n(arst_n), .cfgOrg(cfgOrg),
    .cfgMaskInvEn(cfgMaskInvEn), .linkClk(linkClk), .burstStart(burstStart),
    .cmdA2(cmdA2), .burstChopFour(burstChopFour), .dqIn(dqIn),
    .lowerMaskInvertN(lowerMaskInvertN), .upperMaskInvertN(upperMaskInvertN),
    .linkBusy(linkBusy), .resReady(resReady), .resValid(resValid),
    .resData(resData), .overrunPulse(overrunPulse));
  wcc_ctrl_model i_ctrl(.linkClk(linkClk), .burstStart(burstStart),
    .cmdA2(cmdA2), .burstChopFour(burstChopFour), .dqIn(dqIn),
    .lowerMaskInvertN(lowerMaskInvertN), .upperMaskInvertN(upperMaskInvertN));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (overrunPulse === 1'b1) drops++;

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic send(input wccOrg_t org, input logic a2, input logic chop,
      input logic men, input logic bad);
    wccFrame_t f;
    wccResult_t e, m;
    logic [143:0] t;
    logic [7:0] c0, c1;
    logic w;
    @(negedge sys_clk);
    cfgOrg = org;
    cfgMaskInvEn = men;
    f = '0;
    e = '0;
    m = '0;
    for (int l = 0; l < 18; l++) begin
      for (int b = 0; b < 8; b++) begin
        w = ^(12'((l * 8 + b + 5) * (seq * 2 + 7)));
        if (chop && b > 3) w = 1'b1;
        f.beats[l*8+b] = w;
        if ((l % 9 == 8 && !men) || (org == ORG_X4 && l > 3)) w = 1'b1;
        t[l*8+b] = w;
        if (chop && b < 4) begin
          e.data[l*8+b+(a2 ? 4 : 0)] = w;
          e.data[l*8+b+(a2 ? 0 : 4)] = 1'b1;
        end else if (!chop) e.data[l*8+b] = w;
      end
    end
    c0 = crc8(t[71:0]);
    c1 = crc8(t[143:72]);
    f.a2 = a2;
    f.chop = chop;
    f.beatCrc = '1;
    f.beatLast = '1;
    if (org == ORG_X4) begin
      f.beatCrc[3:0] = c0[3:0];
      f.beatLast[3:0] = c0[7:4];
    end else begin
      f.beatCrc[7:0] = c0;
      f.beatCrc[16:9] = c1;
    end
    f.beatCrc[0] = f.beatCrc[0] ^ bad;
    e.a2 = a2;
    e.chop = chop;
    e.crcCalc = {c1, c0};
    e.crcRecv = {c1, c0 ^ {7'h00, bad}};
    e.crcErr = {1'b0, bad};
    m.a2 = 1'b1;
    m.chop = 1'b1;
    m.crcErr = '1;
    m.fillErr = 1'b1;
    m.crcCalc[7:0] = '1;
    m.crcRecv[7:0] = '1;
    if (org == ORG_X8) m.data[71:0] = '1;
    else m.data = '1;
    if (org == ORG_X16) m.crcCalc = '1;
    if (org == ORG_X16) m.crcRecv = '1;
    expQ.push_back(e);
    maskQ.push_back(m);
    i_ctrl.send(f, seq == 0 ? 3 : 0);
    seq++;
  endtask

  task automatic take();
    wccResult_t e, m;
    int n;
    n = 0;
    @(negedge sys_clk);
    while (resValid !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 400) begin
      errors++;
      test_done();
    end
    e = expQ.pop_front();
    m = maskQ.pop_front();
    check(resData & m, e & m);
    resReady = 1'b1;
    @(negedge sys_clk);
    resReady = 1'b0;
  endtask

  task automatic sc_chop_maps();
    for (int o = 0; o < 3; o++) begin
      for (int a = 0; a < 4; a++) begin
        send(wccOrg_t'(o[1:0]), a[0], 1'b1, a[1], 1'b0);
        take();
      end
    end
  endtask

  task automatic sc_full_burst();
    send(ORG_X8, 1'b0, 1'b0, 1'b1, 1'b0);
    take();
    send(ORG_X16, 1'b0, 1'b0, 1'b0, 1'b0);
    take();
  endtask

  task automatic sc_crc_err();
    send(ORG_X16, 1'b1, 1'b1, 1'b1, 1'b1);
    take();
    send(ORG_X4, 1'b0, 1'b1, 1'b0, 1'b1);
    take();
  endtask

  task automatic sc_order();
    for (int i = 0; i < 3; i++) send(ORG_X16, i[0], 1'b1, 1'b1, 1'b0);
    repeat (3) take();
  endtask

  task automatic sc_fill();
    int k;
    check(drops, 0);
    for (int i = 0; i < 19; i++) send(ORG_X8, i[0], 1'b1, 1'b1, 1'b0);
    repeat (200) @(negedge sys_clk);
    for (k = 0; k < 40; k++) begin
      repeat (4) @(negedge sys_clk);
      if (resValid !== 1'b1) break;
      take();
    end
    check(k + drops, 19);
    check(drops > 0, 1);
    expQ.delete();
    maskQ.delete();
  endtask

  initial begin
    arst_n = 1'b0;
    cfgOrg = ORG_X4;
    cfgMaskInvEn = 1'b0;
    resReady = 1'b0;
    errors = 0;
    compares = 0;
    drops = 0;
    seq = 0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    sc_chop_maps();
    sc_full_burst();
    sc_crc_err();
    sc_order();
    sc_fill();
    test_done();
  end
endmodule
